//--- scl_params.svh
// constants of the serial port configuration loader
// assumes one 250 MHz clock and a 16-bit host output image of 65 words
`ifndef SCL_PARAMS_SVH
`define SCL_PARAMS_SVH

// ==========================================================
// image layout
`define SCL_IMG_WORDS      65
`define SCL_CFG_WORDS      10
`define SCL_OFS_BP_LIMIT   4'h0
`define SCL_OFS_PORT_ON    4'h1
`define SCL_OFS_RX_TERM    4'h2
`define SCL_OFS_SPEED      4'h3
`define SCL_OFS_CHECK_BIT  4'h4
`define SCL_OFS_WORD_LEN   4'h5
`define SCL_OFS_TRAILER    4'h6
`define SCL_OFS_LEAD_MS    4'h7
`define SCL_OFS_TAIL_MS    4'h8
`define SCL_OFS_FLOW       4'h9
`define SCL_READY_BIT      0
`define SCL_REQ_BIT        0
`define SCL_DONE_BIT       1

// ==========================================================
// field limits and codes
`define SCL_TERM_CHAR_BIT  0
`define SCL_MSG_TMO_BIT    1
`define SCL_GAP_TMO_BIT    2
`define SCL_PKT_LEN_BIT    3
`define SCL_CHECK_MAX      16'h0004
`define SCL_LEN_MIN        16'h0005
`define SCL_LEN_MAX        16'h0008
`define SCL_STOP_MIN       16'h0001
`define SCL_STOP_MAX       16'h0002
`define SCL_FLOW_MAX       16'h0003
`define SCL_PORT_ON_VAL    16'h0001
`define SCL_CODE_38K4      16'h0180
`define SCL_CODE_57K6      16'h0240
`define SCL_CODE_115K2     16'h0073

// ==========================================================
// error word bits
`define SCL_ERR_ON         0
`define SCL_ERR_TERM       1
`define SCL_ERR_SPEED      2
`define SCL_ERR_CHECK      3
`define SCL_ERR_LEN        4
`define SCL_ERR_STOP       5
`define SCL_ERR_FLOW       6
`define SCL_ERR_OVF        7

// ==========================================================
// timing
`define SCL_CLK_NS         4
`define SCL_MS_NS          1000000

`endif

//--- scl_pkg.sv
// types of the serial port configuration loader
// assumes nothing beyond the parameter header
package scl_pkg;
  typedef enum logic [1:0] {LD_REQ, LD_LOAD, LD_APPLY, LD_DONE} scl_ld_state_t;
  typedef enum logic [1:0] {RS_IDLE, RS_LEAD, RS_SEND, RS_TAIL} scl_rts_state_t;
endpackage

//--- scl_cfg_mem.sv
// configuration image store, one host write port, registered read
// assumes the host writes words in the same clock domain
`timescale 1ns/100ps
`include "scl_params.svh"
module scl_cfg_mem (
  input  wire logic        clk_i,
  input  wire logic        wr_i,
  input  wire logic [6:0]  waddr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [6:0]  raddr_i,
  output logic      [15:0] rdata_o
);
  logic [15:0] mem_ff [0:`SCL_IMG_WORDS-1];
  logic [15:0] rdata_ff;
  wire         wr_ok = wr_i && (waddr_i < 7'(`SCL_IMG_WORDS));

  // no reset: contents are only used after the host has filled them
  always_ff @(posedge clk_i) begin
    if (wr_ok) begin
      mem_ff[waddr_i] <= wdata_i;
    end
    rdata_ff <= mem_ff[raddr_i];
  end
  assign rdata_o = rdata_ff;
endmodule

//--- scl_config_loader.sv
// configuration loader of a two-port serial gateway, port 1 setup
// assumes host logic on CLK_I writes the output image and reads status
`timescale 1ns/100ps
`include "scl_params.svh"

module scl_config_loader
  import scl_pkg::*;
#(
  parameter int CYC_PER_MS = `SCL_MS_NS / `SCL_CLK_NS
) (
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        OIMG_WR_I,
  input  wire logic [6:0]  OIMG_ADDR_I,
  input  wire logic [15:0] OIMG_DATA_I,
  input  wire logic [15:0] OIMG_CTRL_I,
  output logic      [1:0]  CFG_STATUS_O,
  input  wire logic        BP_XFER_OK_I,
  input  wire logic        BP_XFER_FAIL_I,
  output logic             PORTS_HALT_O,
  output logic             P1_RUN_O,
  output logic             TERM_CHAR_EN_O,
  output logic             MSG_TMO_EN_O,
  output logic             GAP_TMO_EN_O,
  output logic             PKT_LEN_EN_O,
  output logic             STREAM_O,
  output logic      [17:0] BAUD_O,
  output logic      [2:0]  PARITY_O,
  output logic      [3:0]  WORD_LEN_O,
  output logic      [1:0]  TRAILER_BIT_COUNT_O,
  output logic      [1:0]  FLOW_O,
  input  wire logic        RX_OVF_I,
  output logic      [15:0] ERR_WORD_O,
  input  wire logic        TX_REQ_I,
  input  wire logic        TX_END_I,
  output logic             TX_GO_O,
  output logic             RTS_O
);

  // ==========================================================
  // decode helpers
  function automatic logic [17:0] baud_of(input logic [15:0] code);
    logic [17:0] r;
    r = 18'h0;
    unique case (code)
      16'h006e, 16'h012c, 16'h0258, 16'h04b0,
      16'h0960, 16'h12c0, 16'h2580, 16'h4b00: r = {2'h0, code};
      `SCL_CODE_38K4:  r = 18'h09600;
      `SCL_CODE_57K6:  r = 18'h0e100;
      `SCL_CODE_115K2: r = 18'h1c200;
      default:         r = 18'h0;
    endcase
    return r;
  endfunction

  // ==========================================================
  // loader state
  scl_ld_state_t ld_state_ff;
  scl_ld_state_t nxt_ld_state;
  logic [3:0]    ld_idx_ff;
  logic [3:0]    nxt_ld_idx;
  logic [15:0]   rdata;
  logic [15:0]   cfg_ff [0:`SCL_CFG_WORDS-1];

  wire ready_w   = OIMG_CTRL_I[`SCL_READY_BIT];
  wire req_w     = (ld_state_ff == LD_REQ);
  wire done_w    = (ld_state_ff == LD_DONE);
  wire load_w    = (ld_state_ff == LD_LOAD);
  wire last_w    = (ld_idx_ff == 4'(`SCL_CFG_WORDS));
  wire cap_w     = load_w && (ld_idx_ff != 4'h0);
  wire [3:0] cap_idx_w = ld_idx_ff - 4'h1;

  scl_cfg_mem u_mem (
    .clk_i   (CLK_I),
    .wr_i    (OIMG_WR_I),
    .waddr_i (OIMG_ADDR_I),
    .wdata_i (OIMG_DATA_I),
    .raddr_i ({3'h0, ld_idx_ff}),
    .rdata_o (rdata)
  );

  always_comb begin
    nxt_ld_state = ld_state_ff;
    nxt_ld_idx   = 4'h0;
    unique case (ld_state_ff)
      LD_REQ:   if (ready_w) nxt_ld_state = LD_LOAD;
      LD_LOAD: begin
        nxt_ld_idx = ld_idx_ff + 4'h1;
        if (last_w) nxt_ld_state = LD_APPLY;
      end
      LD_APPLY: nxt_ld_state = LD_DONE;
      LD_DONE:  nxt_ld_state = LD_DONE;
    endcase
  end

  // restart always returns to requesting
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ld_state_ff <= LD_REQ;
      ld_idx_ff   <= 4'h0;
    end else begin
      ld_state_ff <= nxt_ld_state;
      ld_idx_ff   <= nxt_ld_idx;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `SCL_CFG_WORDS; gi++) begin : g_cap
      always_ff @(posedge CLK_I) begin
        if (RST_I) begin
          cfg_ff[gi] <= 16'h0;
        end else if (cap_w && cap_idx_w == 4'(gi)) begin
          cfg_ff[gi] <= rdata;
        end
      end
    end
  endgenerate

  assign CFG_STATUS_O[`SCL_REQ_BIT]  = req_w;
  assign CFG_STATUS_O[`SCL_DONE_BIT] = done_w;

  // ==========================================================
  // decoded setup of port 1
  wire [15:0] lim_w   = cfg_ff[`SCL_OFS_BP_LIMIT];
  wire [15:0] on_w    = cfg_ff[`SCL_OFS_PORT_ON];
  wire [15:0] term_w  = cfg_ff[`SCL_OFS_RX_TERM];
  wire [15:0] speed_w = cfg_ff[`SCL_OFS_SPEED];
  wire [15:0] chk_w   = cfg_ff[`SCL_OFS_CHECK_BIT];
  wire [15:0] len_w   = cfg_ff[`SCL_OFS_WORD_LEN];
  wire [15:0] stop_w  = cfg_ff[`SCL_OFS_TRAILER];
  wire [15:0] lead_w  = cfg_ff[`SCL_OFS_LEAD_MS];
  wire [15:0] tail_w  = cfg_ff[`SCL_OFS_TAIL_MS];
  wire [15:0] flow_w  = cfg_ff[`SCL_OFS_FLOW];

  assign TERM_CHAR_EN_O = term_w[`SCL_TERM_CHAR_BIT];
  assign MSG_TMO_EN_O   = term_w[`SCL_MSG_TMO_BIT];
  assign GAP_TMO_EN_O   = term_w[`SCL_GAP_TMO_BIT];
  assign PKT_LEN_EN_O   = term_w[`SCL_PKT_LEN_BIT];
  assign STREAM_O       = (term_w == 16'h0);
  assign PARITY_O       = chk_w[2:0];
  assign WORD_LEN_O     = len_w[3:0];
  assign TRAILER_BIT_COUNT_O = stop_w[1:0];
  assign FLOW_O         = flow_w[1:0];

  // invalid codes are flagged, and the port then stays idle
  logic [15:0] cfg_err;
  always_comb begin
    cfg_err = 16'h0;
    cfg_err[`SCL_ERR_ON]    = (on_w > `SCL_PORT_ON_VAL);
    cfg_err[`SCL_ERR_TERM]  = (term_w[15:4] != 12'h0);
    cfg_err[`SCL_ERR_SPEED] = (baud_of(speed_w) == 18'h0);
    cfg_err[`SCL_ERR_CHECK] = (chk_w > `SCL_CHECK_MAX);
    cfg_err[`SCL_ERR_LEN]   = (len_w < `SCL_LEN_MIN) || (len_w > `SCL_LEN_MAX);
    cfg_err[`SCL_ERR_STOP]  = (stop_w < `SCL_STOP_MIN) || (stop_w > `SCL_STOP_MAX);
    cfg_err[`SCL_ERR_FLOW]  = (flow_w > `SCL_FLOW_MAX);
  end

  logic [15:0] err_ff;
  logic [17:0] baud_ff;
  logic        ovf_ff;
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      err_ff  <= 16'h0;
      baud_ff <= 18'h0;
      ovf_ff  <= 1'b0;
    end else begin
      ovf_ff  <= ovf_ff | RX_OVF_I;
      err_ff  <= done_w ? cfg_err : 16'h0;
      baud_ff <= baud_of(speed_w);
    end
  end
  assign ERR_WORD_O = err_ff | {8'h0, ovf_ff, 7'h0};
  assign BAUD_O     = baud_ff;

  // ==========================================================
  // backplane failure watch
  logic [15:0] fail_cnt_ff;
  logic        halt_ff;
  wire  [15:0] fail_inc_w = (fail_cnt_ff == 16'hffff) ? fail_cnt_ff : fail_cnt_ff + 16'h1;
  wire         halt_hit_w = (lim_w != 16'h0) && (fail_inc_w >= lim_w);
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      fail_cnt_ff <= 16'h0;
      halt_ff     <= 1'b0;
    end else if (done_w) begin
      if (BP_XFER_FAIL_I) begin
        fail_cnt_ff <= fail_inc_w;
        if (halt_hit_w) halt_ff <= 1'b1;
      end else if (BP_XFER_OK_I) begin
        fail_cnt_ff <= 16'h0;
      end
    end
  end
  assign PORTS_HALT_O = halt_ff;

  wire port_run_w = done_w && (on_w == `SCL_PORT_ON_VAL) && !halt_ff && (cfg_err == 16'h0);
  assign P1_RUN_O = port_run_w;

  // ==========================================================
  // RTS lead and tail timing
  scl_rts_state_t rts_ff;
  scl_rts_state_t nxt_rts;
  logic [17:0]    pre_ff;
  logic [15:0]    ms_ff;
  logic [15:0]    nxt_ms;
  wire  tick_w  = (pre_ff == 18'(CYC_PER_MS - 1));
  wire  zero_w  = (ms_ff == 16'h0);

  always_comb begin
    nxt_rts = rts_ff;
    nxt_ms  = (tick_w && !zero_w) ? ms_ff - 16'h1 : ms_ff;
    unique case (rts_ff)
      RS_IDLE: if (TX_REQ_I) begin
        nxt_rts = RS_LEAD;
        nxt_ms  = lead_w;
      end
      RS_LEAD: if (zero_w) nxt_rts = RS_SEND;
      RS_SEND: if (TX_END_I) begin
        nxt_rts = RS_TAIL;
        nxt_ms  = tail_w;
      end
      RS_TAIL: if (zero_w) nxt_rts = RS_IDLE;
    endcase
    if (!port_run_w) nxt_rts = RS_IDLE;
  end

  // prescaler restarts with each delay so a wait never runs short
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rts_ff <= RS_IDLE;
      pre_ff <= 18'h0;
      ms_ff  <= 16'h0;
    end else begin
      rts_ff <= nxt_rts;
      ms_ff  <= nxt_ms;
      pre_ff <= (tick_w || nxt_rts != rts_ff) ? 18'h0 : pre_ff + 18'h1;
    end
  end
  assign RTS_O   = (rts_ff != RS_IDLE);
  assign TX_GO_O = (rts_ff == RS_SEND);

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  AST_REQ_AFTER_RESTART: assert property ($past(RST_I) |-> CFG_STATUS_O == 2'h1)
    else $error("request not raised after restart");
  AST_READY_TO_DONE: assert property (req_w && ready_w |-> ##13 done_w)
    else $error("complete not raised 13 cycles after ready");
  AST_DONE_LOW: assert property (req_w |-> !CFG_STATUS_O[`SCL_DONE_BIT] ##1 !done_w)
    else $error("complete raised while requesting");
  AST_READY_IGNORED: assert property (done_w |=> done_w && !req_w)
    else $error("ready acted on outside request");
  AST_LOADED_WORD: assert property (cap_w && cap_idx_w == 4'h3 |=> speed_w == $past(rdata))
    else $error("image word not captured");
  AST_HALT: assert property (done_w && BP_XFER_FAIL_I && lim_w != 16'h0 && fail_cnt_ff == lim_w - 16'h1
                             |=> PORTS_HALT_O ##1 !RTS_O)
    else $error("ports not stopped at failure limit");
  AST_ZERO_LIMIT: assert property (lim_w == 16'h0 |=> !PORTS_HALT_O)
    else $error("ports stopped with zero limit");
  AST_PORT_OFF: assert property (done_w && on_w == 16'h0 |-> !P1_RUN_O ##1 !RTS_O)
    else $error("disabled port active");
  AST_STREAM: assert property (STREAM_O |-> !(TERM_CHAR_EN_O || MSG_TMO_EN_O || GAP_TMO_EN_O || PKT_LEN_EN_O))
    else $error("stream mode with termination");
  AST_BAUD: assert property (done_w && speed_w == `SCL_CODE_115K2 |=> BAUD_O == 18'h1c200)
    else $error("speed code misdecoded");
  AST_LEAD_ZERO: assert property (rts_ff == RS_IDLE && TX_REQ_I && port_run_w && lead_w == 16'h0
                                  ##1 port_run_w |=> TX_GO_O && RTS_O)
    else $error("zero lead delay not honoured");
  AST_TAIL_HOLD: assert property (TX_GO_O && TX_END_I && port_run_w |=> RTS_O && !TX_GO_O)
    else $error("RTS dropped at end of message");
  AST_OVF: assert property (RX_OVF_I |=> ERR_WORD_O[`SCL_ERR_OVF])
    else $error("overflow not reported");

  COV_LOAD: cover property (req_w && ready_w ##13 done_w);
  COV_HALT: cover property ($rose(PORTS_HALT_O));
  COV_TAIL: cover property (rts_ff == RS_TAIL ##1 rts_ff == RS_IDLE);
endmodule

//--- scl_host_model.sv
// host controller model: fills the output image and raises ready
// assumes the loader status port and the bench clock; drives just after each edge
`timescale 1ns/100ps
module scl_host_model (
  input  wire logic        clk_i,
  input  wire logic [1:0]  status_i,
  output logic             wr_o,
  output logic      [6:0]  addr_o,
  output logic      [15:0] data_o,
  output logic      [15:0] ctrl_o
);
  initial begin
    wr_o = 1'b0;
    addr_o = 7'h00;
    data_o = 16'h0000;
    ctrl_o = 16'h0000;
  end

  // ==========================================================
  // restart drops ready so stale words are never taken
  task automatic clear();
    ctrl_o = 16'h0000;
  endtask

  // ==========================================================
  // lag models a slow ladder scan; wait_req low raises ready uninvited
  task automatic send(input logic [15:0] cfg [10], input int lag, input bit wait_req);
    int i;
    ctrl_o = 16'h0000;
    for (i = 0; i < 50 && wait_req && status_i[0] !== 1'b1; i++) @(posedge clk_i);
    repeat (lag) @(posedge clk_i);
    for (i = 0; i < 65; i++) begin
      @(posedge clk_i);
      #1;
      wr_o = 1'b1;
      addr_o = i[6:0];
      data_o = (i < 10) ? cfg[i] : ~cfg[i % 10];
    end
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    data_o = ~data_o;
    ctrl_o = 16'h0001;
  endtask
endmodule

//--- scl_config_loader_tb.sv
// self-checking bench of the configuration loader
// assumes the loader with a 4-cycle millisecond; host model fills the image
`timescale 1ns/100ps
module scl_config_loader_tb;
  import scl_pkg::*;
  localparam int CPM = 4;
  logic clk = 1'b0, rst = 1'b1, bp_ok = 1'b0, bp_fail = 1'b0, ovf = 1'b0, tx_req = 1'b0, tx_end = 1'b0;
  logic wr, halt, run, tc, mt, gt, pl, strm, go, rts;
  logic [6:0] addr;
  logic [15:0] data, ctrl, err;
  logic [1:0] status, tbc, flow;
  logic [17:0] baud;
  logic [2:0] par;
  logic [3:0] wl;
  int failures = 0, n_compared = 0, cyc = 0;
  // words: limit, on, term, speed, parity, length, stop, lead, tail, flow
  logic [15:0] rows [6][10] = '{
    '{16'h3, 16'h1, 16'h5, 16'h180, 16'h1, 16'h5, 16'h1, 16'h2, 16'h1, 16'h0},
    '{16'h0, 16'h1, 16'ha, 16'h240, 16'h2, 16'h6, 16'h2, 16'h0, 16'h0, 16'h1},
    '{16'h0, 16'h1, 16'h0, 16'h73, 16'h3, 16'h7, 16'h1, 16'h1, 16'h2, 16'h2},
    '{16'h0, 16'h0, 16'hf, 16'h4b00, 16'h4, 16'h8, 16'h2, 16'h0, 16'h0, 16'h3},
    '{16'h0, 16'h1, 16'h10, 16'h3e8, 16'h5, 16'h9, 16'h3, 16'h0, 16'h0, 16'h3},
    '{16'h0, 16'h2, 16'h0, 16'h6e, 16'h0, 16'h8, 16'h1, 16'h0, 16'h0, 16'h4}};

  always #2 clk = ~clk;

  scl_host_model hst (.clk_i(clk), .status_i(status), .wr_o(wr), .addr_o(addr), .data_o(data), .ctrl_o(ctrl));

  scl_config_loader #(.CYC_PER_MS(CPM)) dut (
    .CLK_I(clk), .RST_I(rst), .OIMG_WR_I(wr), .OIMG_ADDR_I(addr), .OIMG_DATA_I(data), .OIMG_CTRL_I(ctrl),
    .CFG_STATUS_O(status), .BP_XFER_OK_I(bp_ok), .BP_XFER_FAIL_I(bp_fail), .PORTS_HALT_O(halt), .P1_RUN_O(run),
    .TERM_CHAR_EN_O(tc), .MSG_TMO_EN_O(mt), .GAP_TMO_EN_O(gt), .PKT_LEN_EN_O(pl), .STREAM_O(strm), .BAUD_O(baud),
    .PARITY_O(par), .WORD_LEN_O(wl), .TRAILER_BIT_COUNT_O(tbc), .FLOW_O(flow), .RX_OVF_I(ovf), .ERR_WORD_O(err),
    .TX_REQ_I(tx_req), .TX_END_I(tx_end), .TX_GO_O(go), .RTS_O(rts));

  // ==========================================================
  // shared helpers
  task automatic check(input string nm, input logic [17:0] seen, input logic [17:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end

  function automatic logic [17:0] exp_baud(input logic [15:0] w);
    case (w)
      16'h6e, 16'h12c, 16'h258, 16'h4b0, 16'h960, 16'h12c0, 16'h2580, 16'h4b00: return {2'b00, w};
      16'h180: return 18'h9600;
      16'h240: return 18'he100;
      16'h73: return 18'h1c200;
      default: return 18'h0;
    endcase
  endfunction

  function automatic logic [7:0] exp_err(input int r);
    logic [7:0] e;
    e = 8'h00;
    e[0] = rows[r][1] > 16'h1;
    e[1] = |rows[r][2][15:4];
    e[2] = exp_baud(rows[r][3]) == 18'h0;
    e[3] = rows[r][4] > 16'h4;
    e[4] = rows[r][5] < 16'h5 || rows[r][5] > 16'h8;
    e[5] = rows[r][6] < 16'h1 || rows[r][6] > 16'h2;
    e[6] = rows[r][9] > 16'h3;
    return e;
  endfunction

  // ==========================================================
  // scenarios
  task automatic restart(input int n);
    rst = 1'b1;
    hst.clear();
    tick(n);
    rst = 1'b0;
    check("status_req", status, 2'b01);
    check("stream_rst", strm, 1'b1);
    check("rts_rst", rts, 1'b0);
  endtask

  task automatic t_cfg(input int r);
    int k;
    restart(2);
    hst.send(rows[r], r, 1'b1);
    for (k = 0; k < 30 && status !== 2'b10; k++) tick(1);
    check("complete", status, 2'b10);
    tick(2);
    check("term_char", tc, rows[r][2][0]);
    check("msg_tmo", mt, rows[r][2][1]);
    check("gap_tmo", gt, rows[r][2][2]);
    check("pkt_len", pl, rows[r][2][3]);
    check("stream", strm, rows[r][2] == 16'h0);
    check("baud", baud, exp_baud(rows[r][3]));
    check("parity", par, rows[r][4][2:0]);
    check("word_len", wl, rows[r][5][3:0]);
    check("stop", tbc, rows[r][6][1:0]);
    check("flow", flow, rows[r][9][1:0]);
    check("err", err, {8'h00, exp_err(r)});
    check("run", run, rows[r][1] == 16'h1 && exp_err(r) == 8'h0);
    $display("test cfg %0d done", r);
  endtask

  task automatic pulse(input logic f);
    bp_fail = f;
    bp_ok = ~f;
    tick(1);
    bp_fail = 1'b0;
    bp_ok = 1'b0;
    tick(1);
  endtask

  task automatic t_fail();
    t_cfg(0);
    pulse(1'b1);
    pulse(1'b1);
    pulse(1'b0);
    pulse(1'b1);
    pulse(1'b1);
    check("halt_below", halt, 1'b0);
    pulse(1'b1);
    tick(1);
    check("halt_limit", halt, 1'b1);
    check("run_halted", run, 1'b0);
    t_cfg(1);
    repeat (6) pulse(1'b1);
    check("halt_zero", halt, 1'b0);
    $display("test fail done");
  endtask

  // lead and tail counts allow the prescaler restart slack
  task automatic t_rts(input int r);
    int n;
    int lead;
    int tail;
    t_cfg(r);
    lead = int'(rows[r][7]) * CPM;
    tail = int'(rows[r][8]) * CPM;
    tx_req = 1'b1;
    for (n = 0; n < 4 && rts !== 1'b1; n++) tick(1);
    check("rts_on", rts, 1'b1);
    check("go_early", go, 1'b0);
    for (n = 0; n < 100 && go !== 1'b1; n++) tick(1);
    check("lead", n >= lead && n <= lead + 2, 1'b1);
    tx_end = 1'b1;
    tx_req = 1'b0;
    tick(1);
    tx_end = 1'b0;
    for (n = 1; n < 100 && rts !== 1'b0; n++) tick(1);
    check("tail", n >= tail && n <= tail + 3, 1'b1);
    check("go_off", go, 1'b0);
    $display("test rts %0d done", r);
  endtask

  task automatic t_idle_ovf();
    t_cfg(3);
    tx_req = 1'b1;
    tick(10);
    check("rts_off_port", rts, 1'b0);
    tx_req = 1'b0;
    ovf = 1'b1;
    tick(1);
    ovf = 1'b0;
    tick(5);
    check("ovf_flag", err[7], 1'b1);
    $display("test idle done");
  endtask

  task automatic t_late_ready();
    t_cfg(0);
    hst.send(rows[1], 0, 1'b0);
    tick(20);
    check("status_hold", status, 2'b10);
    check("len_hold", wl, 4'h5);
    check("speed_hold", baud, 18'h9600);
    $display("test ready done");
  endtask

  initial begin
    restart(20);
    for (int r = 0; r < 6; r++) t_cfg(r);
    t_fail();
    t_rts(0);
    t_rts(1);
    t_rts(2);
    t_idle_ovf();
    t_late_ready();
    final_report();
  end
endmodule
